// ### dpr_pkg.sv
/*
 * Shared constants and types for the dual-port block memory and its
 * register-driven user end.
 * Assumes one clock (hclk) and one asynchronous active-low reset for both ends.
 */
// Contract
// - 36 Kb store, or two 18 Kb halves
// - 36 Kb widths 1, 2, 4, 9, 18, 36
// - 18 Kb widths 1, 2, 4, 9, 18
// - two symmetric independent ports, shared array
// - read width may differ from write width
// - simple dual-port: 72 or 36 bits
// - two 36 Kb cascade to 64K x 1
// - byte write enables on wide ports
// - inputs captured on port clock edge
// - write enable selects read or write behaviour
// - write and read take one edge each
// - outputs hold; latch mode by default
// - optional output register adds one cycle
// - set/reset loads configured initial output value
// - no set/reset while read decoder enabled
// - register mode reset needs register enable
// - latch mode reset needs port enable
// - parity only on 9, 18, 36 widths
// - narrow partner makes wide side parity-less
// - no parity with mixed narrow/wide widths
// - array contents initialised or cleared at configuration
// - write-through, read-first, hold; write-through default
// - disabled port neither writes nor changes output; in register mode the register still loads on register enable
`default_nettype none

package dpr_pkg;

	// -------------------------------------------------------------------
	// array and port geometry
	// -------------------------------------------------------------------
	localparam int DPR_KBITS_FULL = 36;
	localparam int DPR_KBITS_HALF = 18;
	localparam int DPR_DW         = 64;   // data bits per port bus
	localparam int DPR_PW         = 8;    // parity bits per port bus
	localparam int DPR_OW         = 72;   // data plus parity
	localparam int DPR_AW         = 16;
	localparam int DPR_LANES      = 8;
	localparam int DPR_CASC_BIT   = 15;   // block select in cascade
	localparam int DPR_W_WIDE     = 36;

	// read-during-write behaviour, gray along wt -> rf -> nc
	typedef enum logic [1:0] {
		DPR_WT = 2'h0,
		DPR_RF = 2'h1,
		DPR_NC = 2'h3
	} dpr_wmode_t;

	typedef enum logic [1:0] {
		DPR_CASC_NONE  = 2'h0,
		DPR_CASC_LOWER = 2'h1,
		DPR_CASC_UPPER = 2'h3
	} dpr_casc_t;

	// -------------------------------------------------------------------
	// user-end register map, byte offsets within one port window
	// -------------------------------------------------------------------
	localparam logic [5:0] DPR_PORT_B_BASE = 6'h20;
	localparam logic [4:0] DPR_OFF_CMD     = 5'h00;
	localparam logic [4:0] DPR_OFF_WLO     = 5'h04;
	localparam logic [4:0] DPR_OFF_WHI     = 5'h08;
	localparam logic [4:0] DPR_OFF_WPAR    = 5'h0C;
	localparam logic [4:0] DPR_OFF_RLO     = 5'h10;
	localparam logic [4:0] DPR_OFF_RHI     = 5'h14;
	localparam logic [4:0] DPR_OFF_RPAR    = 5'h18;

	// command register fields
	localparam int DPR_CMD_EN    = 16;
	localparam int DPR_CMD_WE    = 17;
	localparam int DPR_CMD_SSR   = 25;
	localparam int DPR_CMD_OUTPUT_REG_ENABLE = 26;

	localparam logic [31:0] DPR_CMD_RESET = 32'h0000_0000;

endpackage : dpr_pkg

`default_nettype wire

// ### dpr_if.sv
/*
 * Port bundle between the memory block and the user logic; index 0 is
 * port A, index 1 is port B.
 * Assumes both ends run on the same clock and reset.
 */
`default_nettype none

interface dpr_if;
	logic [1:0]                  en;
	logic [1:0][7:0]             we;
	logic [1:0][15:0]            addr;
	logic [1:0][63:0]            din;
	logic [1:0][7:0]             parity_in;
	logic [1:0]                  sync_output_set_reset;
	logic [1:0]                  output_reg_enable;
	logic [1:0][63:0]            dout;
	logic [1:0][7:0]             parity_out;

	modport mem (
		input  en, we, addr, din, parity_in, sync_output_set_reset, output_reg_enable,
		output dout, parity_out
	);
	modport user (
		output en, we, addr, din, parity_in, sync_output_set_reset, output_reg_enable,
		input  dout, parity_out
	);
endinterface : dpr_if

`default_nettype wire

// ### dpr_mem.sv
/*
 * True dual-port block memory with per-port widths, read-during-write
 * modes, optional output register, set/reset, byte enables and cascade.
 * Assumes inputs are synchronous to hclk; same-address conflicts between
 * ports are the user's problem, port B wins a same-cycle double write.
 */
`default_nettype none

module dpr_mem
	import dpr_pkg::*;
#(
	parameter int          KBITS   = DPR_KBITS_FULL,
	parameter int          RW_A    = 36,
	parameter int          WW_A    = 36,
	parameter int          RW_B    = 36,
	parameter int          WW_B    = 36,
	parameter bit          SDP     = 1'b0,
	parameter dpr_wmode_t  WMODE_A = DPR_WT,
	parameter dpr_wmode_t  WMODE_B = DPR_WT,
	parameter bit          OREG_A  = 1'b0,
	parameter bit          OREG_B  = 1'b0,
	parameter logic [71:0] INIT_A  = 72'h00_0000_0000_0000_0000,
	parameter logic [71:0] INIT_B  = 72'h00_0000_0000_0000_0000,
	parameter logic [31:0] FILL    = 32'h0000_0000,
	parameter dpr_casc_t   CASC    = DPR_CASC_NONE
) (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	dpr_if.mem              port,
	input  wire logic [1:0] casc_in,
	output logic      [1:0] casc_out
);

	// -------------------------------------------------------------------
	// configuration
	// -------------------------------------------------------------------
	localparam int DBITS = KBITS * 1024 * 8 / 9;
	localparam int PBITS = KBITS * 1024 / 9;
	localparam int SDPW  = 2 * ((KBITS == DPR_KBITS_FULL) ? DPR_W_WIDE : 18);

	localparam int          RW   [2] = '{RW_A, RW_B};
	localparam int          WW   [2] = '{WW_A, WW_B};
	localparam dpr_wmode_t  WM   [2] = '{WMODE_A, WMODE_B};
	localparam bit          OREG [2] = '{OREG_A, OREG_B};
	localparam logic [71:0] INIT [2] = '{INIT_A, INIT_B};

	function automatic int nbytes(input int w);
		return (w >= 9) ? w / 9 : 0;
	endfunction : nbytes

	function automatic int dwid(input int w);
		return (w >= 9) ? nbytes(w) * 8 : w;
	endfunction : dwid

	function automatic bit legal(input int w, input bit sdp_side);
		if (sdp_side)
			return w == SDPW;
		return w == 1 || w == 2 || w == 4 || w == 9 || w == 18
			|| (w == DPR_W_WIDE && KBITS == DPR_KBITS_FULL);
	endfunction : legal

	// narrow partner on any side strips parity from the wide side
	localparam int  WMIN   = (RW_A < WW_A ? RW_A : WW_A) < (RW_B < WW_B ? RW_B : WW_B)
		? (RW_A < WW_A ? RW_A : WW_A) : (RW_B < WW_B ? RW_B : WW_B);
	localparam int  WMAX   = (RW_A > WW_A ? RW_A : WW_A) > (RW_B > WW_B ? RW_B : WW_B)
		? (RW_A > WW_A ? RW_A : WW_A) : (RW_B > WW_B ? RW_B : WW_B);
	localparam bit  PAR_OK = !(WMIN < 9 && WMAX >= 9);

	// -------------------------------------------------------------------
	// elaboration checks
	// -------------------------------------------------------------------
	if (KBITS != DPR_KBITS_FULL && KBITS != DPR_KBITS_HALF) begin : g_bad_size
		$error("dpr_mem: size must be 36 or 18 Kb");
	end
	if (!legal(RW_A, SDP) || !legal(WW_A, 1'b0) || !legal(RW_B, 1'b0)
		|| !legal(WW_B, SDP)) begin : g_bad_width
		$error("dpr_mem: unsupported port width");
	end
	if (CASC != DPR_CASC_NONE && (KBITS != DPR_KBITS_FULL || WMAX != 1)) begin : g_bad_casc
		$error("dpr_mem: cascade needs 36 Kb and x1 ports");
	end

	// -------------------------------------------------------------------
	// storage and per-port decode
	// -------------------------------------------------------------------
	logic [DBITS-1:0] mem_q;
	logic [PBITS-1:0] par_q;
	logic [71:0]      lat_q [2];
	logic [71:0]      reg_q [2];
	logic [1:0]       sel_lat_q;
	logic [1:0]       sel_reg_q;
	logic [1:0]       hit;
	logic [1:0]       wr;
	logic [1:0]       rd_ok;
	logic [71:0]      fin [2];

	// byte lane of a written data or parity bit
	function automatic logic lane_on(input int p, input int pos, input bit is_par);
		int lane;
		lane = (WW[p] >= 18) ? (is_par ? pos : pos / 8) : 0;
		return port.we[p][lane];
	endfunction : lane_on

	// decode of each port; cascade picks the block with address bit 15
	always_comb begin
		for (int p = 0; p < 2; p++) begin
			hit[p] = (CASC == DPR_CASC_NONE)
				|| (port.addr[p][DPR_CASC_BIT] == (CASC == DPR_CASC_UPPER));
			wr[p] = port.en[p] && hit[p] && !(SDP && p == 0)
				&& (|(port.we[p] & 8'((9'h001 << ((WW[p] >= 18) ? nbytes(WW[p]) : 1)) - 9'h001)));
			rd_ok[p] = port.en[p] && hit[p] && !(SDP && p == 1);
		end
	end

	// array read at this edge; write-through overlays the incoming word
	function automatic logic [71:0] rd_word(input int p);
		logic [71:0] r;
		int rw;
		int ww;
		int rb;
		int wb;
		int idx;
		int off;
		logic wt;
		r  = '0;
		rw = dwid(RW[p]);
		ww = dwid(WW[p]);
		rb = (int'(port.addr[p]) * rw) % DBITS;
		wb = (int'(port.addr[p]) * ww) % DBITS;
		wt = (WM[p] == DPR_WT) && wr[p];
		for (int j = 0; j < DPR_DW; j++) begin
			if (j < rw) begin
				idx  = rb + j;
				off  = idx - wb;
				r[j] = (wt && off >= 0 && off < ww && lane_on(p, off, 1'b0))
					? port.din[p][off] : mem_q[idx];
			end
		end
		rb = (int'(port.addr[p]) * nbytes(RW[p])) % PBITS;
		wb = (int'(port.addr[p]) * nbytes(WW[p])) % PBITS;
		for (int k = 0; k < DPR_PW; k++) begin
			if (PAR_OK && k < nbytes(RW[p])) begin
				idx = rb + k;
				off = idx - wb;
				r[DPR_DW+k] = (wt && off >= 0 && off < nbytes(WW[p]) && lane_on(p, off, 1'b1))
					? port.parity_in[p][off] : par_q[idx];
			end
		end
		return r;
	endfunction : rd_word

	// -------------------------------------------------------------------
	// array writes
	// -------------------------------------------------------------------
	// reset loads the fill pattern, standing in for configuration load
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < DBITS; i++)
				mem_q[i] <= FILL[i % 32];
			for (int i = 0; i < PBITS; i++)
				par_q[i] <= FILL[i % 32];
		end else begin
			for (int p = 0; p < 2; p++) begin
				if (wr[p]) begin
					for (int j = 0; j < DPR_DW; j++)
						if (j < dwid(WW[p]) && lane_on(p, j, 1'b0))
							mem_q[(int'(port.addr[p]) * dwid(WW[p]) + j) % DBITS] <= port.din[p][j];
					for (int k = 0; k < DPR_PW; k++)
						if (PAR_OK && k < nbytes(WW[p]) && lane_on(p, k, 1'b1))
							par_q[(int'(port.addr[p]) * nbytes(WW[p]) + k) % PBITS]
								<= port.parity_in[p][k];
				end
			end
		end
	end

	// -------------------------------------------------------------------
	// output latch
	// -------------------------------------------------------------------
	// the latch holds until the port reads again, writes in write-through or read-first mode, or takes set/reset without the output register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int p = 0; p < 2; p++)
				lat_q[p] <= INIT[p];
			sel_lat_q <= 2'h0;
		end else begin
			for (int p = 0; p < 2; p++) begin
				if (port.en[p] && !OREG[p] && port.sync_output_set_reset[p])
					lat_q[p] <= INIT[p];
				else if (rd_ok[p] && !(wr[p] && WM[p] == DPR_NC))
					lat_q[p] <= rd_word(p);
				if (port.en[p])
					sel_lat_q[p] <= port.addr[p][DPR_CASC_BIT];
			end
		end
	end

	// -------------------------------------------------------------------
	// optional output register
	// -------------------------------------------------------------------
	// costs one cycle of latency but shortens the clock-to-out path
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int p = 0; p < 2; p++)
				reg_q[p] <= INIT[p];
			sel_reg_q <= 2'h0;
		end else begin
			for (int p = 0; p < 2; p++) begin
				if (OREG[p] && port.output_reg_enable[p]) begin
					reg_q[p]     <= port.sync_output_set_reset[p] ? INIT[p] : lat_q[p];
					sel_reg_q[p] <= sel_lat_q[p];
				end
			end
		end
	end

	// -------------------------------------------------------------------
	// output selection and cascade
	// -------------------------------------------------------------------
	// upper block of a cascade passes the lower block's bit when not selected
	always_comb begin
		for (int p = 0; p < 2; p++) begin
			fin[p] = OREG[p] ? reg_q[p] : lat_q[p];
			if (CASC == DPR_CASC_UPPER && !(OREG[p] ? sel_reg_q[p] : sel_lat_q[p]))
				fin[p][0] = casc_in[p];
		end
	end

	assign port.dout       = {fin[1][DPR_DW-1:0], fin[0][DPR_DW-1:0]};
	assign port.parity_out = {fin[1][DPR_OW-1:DPR_DW], fin[0][DPR_OW-1:DPR_DW]};
	assign casc_out        = {fin[1][0], fin[0][0]};

endmodule : dpr_mem

`default_nettype wire

// ### dpr_ctl.sv
/*
 * User end of the memory: an AHB-Lite slave whose registers issue one
 * command per write to each memory port and show the port outputs.
 * Assumes a single master, single word transfers, hclk shared with memory.
 */
`default_nettype none

module dpr_ctl
	import dpr_pkg::*;
#(
	parameter bit ECC_READ = 1'b0,
	parameter bit PAR_USE  = 1'b1
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	dpr_if.user              port
);

	// -------------------------------------------------------------------
	// state
	// -------------------------------------------------------------------
	logic [31:0] cmd_q  [2];
	logic [31:0] wlo_q  [2];
	logic [31:0] whi_q  [2];
	logic [7:0]  wpar_q [2];
	logic [1:0]  en_q;
	logic [7:0]  we_q   [2];
	logic [1:0]  ssr_q;
	logic        wact_q;
	logic        wport_q;
	logic [4:0]  wofs_q;
	logic        sel_ok;

	// mapped: low 64 bytes only, whole aligned words
	assign sel_ok = hsel && htrans[1] && hready && haddr[31:6] == 26'h0
		&& hsize == 3'h2 && haddr[1:0] == 2'h0;

	function automatic logic [31:0] rd_reg(input int p, input logic [4:0] ofs);
		case (ofs)
			DPR_OFF_CMD:  return cmd_q[p];
			DPR_OFF_WLO:  return wlo_q[p];
			DPR_OFF_WHI:  return whi_q[p];
			DPR_OFF_WPAR: return {24'h0, wpar_q[p]};
			DPR_OFF_RLO:  return port.dout[p][31:0];
			DPR_OFF_RHI:  return port.dout[p][63:32];
			DPR_OFF_RPAR: return {24'h0, port.parity_out[p]};
			default:      return 32'h0000_0000;
		endcase
	endfunction : rd_reg

	// -------------------------------------------------------------------
	// bus side: zero wait states, always OKAY
	// -------------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h0000_0000;
			wact_q    <= 1'b0;
			wport_q   <= 1'b0;
			wofs_q    <= 5'h00;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wact_q    <= sel_ok && hwrite;
			wport_q   <= haddr[5];
			wofs_q    <= haddr[4:0];
			if (sel_ok && !hwrite)
				hrdata <= rd_reg(int'(haddr[5]), haddr[4:0]);
			else if (hsel && htrans[1] && hready)
				hrdata <= 32'h0000_0000;
		end
	end

	// -------------------------------------------------------------------
	// register writes and command issue
	// -------------------------------------------------------------------
	// each command write pulses enable, write enables and set/reset for exactly one cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int p = 0; p < 2; p++) begin
				cmd_q[p]  <= DPR_CMD_RESET;
				wlo_q[p]  <= 32'h0000_0000;
				whi_q[p]  <= 32'h0000_0000;
				wpar_q[p] <= 8'h00;
				we_q[p]   <= 8'h00;
			end
			en_q  <= 2'h0;
			ssr_q <= 2'h0;
		end else begin
			en_q  <= 2'h0;
			ssr_q <= 2'h0;
			for (int p = 0; p < 2; p++)
				we_q[p] <= 8'h00;
			if (wact_q) begin
				case (wofs_q)
					DPR_OFF_CMD: begin
						cmd_q[wport_q] <= hwdata;
						en_q[wport_q]  <= hwdata[DPR_CMD_EN];
						we_q[wport_q]  <= hwdata[DPR_CMD_WE+:DPR_LANES];
						// set/reset is dropped while reads are error-corrected
						ssr_q[wport_q] <= hwdata[DPR_CMD_SSR] && !ECC_READ;
					end
					DPR_OFF_WLO:  wlo_q[wport_q]  <= hwdata;
					DPR_OFF_WHI:  whi_q[wport_q]  <= hwdata;
					DPR_OFF_WPAR: wpar_q[wport_q] <= PAR_USE ? hwdata[7:0] : 8'h00;
					default: ;
				endcase
			end
		end
	end

	// -------------------------------------------------------------------
	// port drive; register enable is a level held in the command word
	// -------------------------------------------------------------------
	assign port.en                    = en_q;
	assign port.sync_output_set_reset = ssr_q;
	assign port.we                    = {we_q[1], we_q[0]};
	assign port.addr                  = {cmd_q[1][15:0], cmd_q[0][15:0]};
	assign port.din                   = {whi_q[1], wlo_q[1], whi_q[0], wlo_q[0]};
	assign port.parity_in             = {wpar_q[1], wpar_q[0]};
	assign port.output_reg_enable     = {cmd_q[1][DPR_CMD_OUTPUT_REG_ENABLE],
		cmd_q[0][DPR_CMD_OUTPUT_REG_ENABLE]};

endmodule : dpr_ctl

`default_nettype wire

// ### dpr_asserts.sv
/*
 * Concurrent checks on the memory port bundle between the two ends.
 * Assumes port A in latch write-through mode, port B registered read-first,
 * both on hclk with an asynchronous active-low reset.
 */
`default_nettype none

module dpr_asserts #(
	parameter logic [31:0] INIT_A_LO = 32'h0000_0000,
	parameter logic [31:0] INIT_B_LO = 32'h0000_0000
) (
	input wire logic             hclk,
	input wire logic             hresetn,
	input wire logic [1:0]       en,
	input wire logic [1:0][7:0]  we,
	input wire logic [1:0][63:0] din,
	input wire logic [1:0][7:0]  parity_in,
	input wire logic [1:0]       sync_output_set_reset,
	input wire logic [1:0]       output_reg_enable,
	input wire logic [1:0][63:0] dout,
	input wire logic [1:0][7:0]  parity_out
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// ------------------------------------------------------------------
	// sequences
	// ------------------------------------------------------------------
	// full-word write on port A without set/reset
	sequence s_full_wr_a;
		en[0] && we[0][3:0] == 4'hF && !sync_output_set_reset[0];
	endsequence
	// register already loaded from a quiet latch, then a new access
	sequence s_armed_b;
		(output_reg_enable[1] && !en[1]) ##1 (en[1] && output_reg_enable[1]);
	endsequence

	// ------------------------------------------------------------------
	// properties
	// ------------------------------------------------------------------
	a_idle_hold_a: assert property (!en[0]
		|=> $stable(dout[0]) && $stable(parity_out[0]))
		else $error("port A output moved while disabled");
	a_wt_data_a: assert property (s_full_wr_a
		|=> dout[0][31:0] == $past(din[0][31:0]))
		else $error("port A write-through data wrong");
	a_wt_parity_a: assert property (s_full_wr_a
		|=> parity_out[0][3:0] == $past(parity_in[0][3:0]))
		else $error("port A write-through parity wrong");
	a_lane_two_a: assert property (en[0] && !sync_output_set_reset[0] && we[0][2]
		|=> dout[0][23:16] == $past(din[0][23:16]))
		else $error("port A enabled lane not shown");
	a_ssr_init_a: assert property (en[0] && sync_output_set_reset[0]
		|=> dout[0][31:0] == INIT_A_LO && parity_out[0][3:0] == 4'h0)
		else $error("port A set/reset value wrong");
	a_ssr_gate_a: assert property (sync_output_set_reset[0] && !en[0]
		|=> $stable(dout[0]))
		else $error("port A reset acted without enable");
	a_oreg_hold_b: assert property (!output_reg_enable[1]
		|=> $stable(dout[1]) && $stable(parity_out[1]))
		else $error("port B register moved without enable");
	a_ssr_reg_b: assert property (sync_output_set_reset[1] && output_reg_enable[1]
		|=> dout[1][31:0] == INIT_B_LO && parity_out[1][3:0] == 4'h0)
		else $error("port B register set/reset value wrong");
	a_oreg_late_b: assert property (s_armed_b |=> $stable(dout[1]))
		else $error("port B output came without register delay");
endmodule : dpr_asserts

`default_nettype wire

// ### tb_top.sv
/*
 * Self-checking bench: AHB-Lite master into the user end, which drives
 * the memory across the port bundle.
 * Assumes hreadyout is fed back as hready and a 25 MHz hclk.
 */
`default_nettype none

module tb_top
	import dpr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------------
	// configuration and signals
	// ------------------------------------------------------------------
	localparam logic [71:0] INIT_A = 72'h00_0000_0000_1234_5678;
	localparam logic [71:0] INIT_B = 72'h00_0000_0000_9ABC_DEF0;
	localparam logic [31:0] FILL   = 32'hC3A5_5A3C;
	logic        hclk      = 1'b0;
	logic        hresetn   = 1'b0;
	logic        hsel      = 1'b0;
	logic        hwrite    = 1'b0;
	logic [1:0]  htrans    = 2'h0;
	logic [2:0]  hsize     = 3'h2;
	logic [31:0] haddr     = 32'h0;
	logic [31:0] hwdata    = 32'h0;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	int          fail_count  = 0;
	int          check_count = 0;

	// 40 ns period
	always #20 hclk = ~hclk;

	dpr_if u_dpr_if ();
	dpr_mem #(.WMODE_B(DPR_RF), .OREG_B(1'b1), .INIT_A(INIT_A), .INIT_B(INIT_B), .FILL(FILL))
	u_dpr_mem (.hclk(hclk), .hresetn(hresetn), .port(u_dpr_if), .casc_in(2'h0), .casc_out());
	dpr_ctl u_dpr_ctl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .port(u_dpr_if));
	dpr_asserts #(.INIT_A_LO(INIT_A[31:0]), .INIT_B_LO(INIT_B[31:0]))
	u_dpr_asserts (.hclk(hclk), .hresetn(hresetn),
		.en(u_dpr_if.en), .we(u_dpr_if.we), .din(u_dpr_if.din), .parity_in(u_dpr_if.parity_in),
		.sync_output_set_reset(u_dpr_if.sync_output_set_reset),
		.output_reg_enable(u_dpr_if.output_reg_enable), .dout(u_dpr_if.dout),
		.parity_out(u_dpr_if.parity_out));

	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// bounded wait for hready; a hang ends the run as a mismatch
	task automatic edge_ready();
		int n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 50) begin
				fail_count++;
				results();
			end
			@(posedge hclk);
		end
	endtask : edge_ready

	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		edge_ready();
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		edge_ready();
		rd = hrdata;
	endtask : ahb

	function automatic logic [31:0] ra(input logic p, input logic [4:0] off);
		return {26'h0, (p ? DPR_PORT_B_BASE : 6'h00) | {1'b0, off}};
	endfunction : ra

	// ctl is {set/reset, enable, register enable}; waits out the latency
	task automatic op(input logic p, input logic [15:0] a, input logic [3:0] w,
		input logic [2:0] ctl, input logic [31:0] d, input logic [3:0] pi);
		logic [31:0] x;
		ahb(1'b1, ra(p, DPR_OFF_WLO), d, x);
		ahb(1'b1, ra(p, DPR_OFF_WPAR), {28'h0, pi}, x);
		ahb(1'b1, ra(p, DPR_OFF_CMD), {5'h00, ctl[0], ctl[2], 4'h0, w, ctl[1], a}, x);
		repeat (4) @(posedge hclk);
	endtask : op

	task automatic pchk(input logic p, input logic [31:0] lo, input logic [3:0] par);
		logic [31:0] x;
		ahb(1'b0, ra(p, DPR_OFF_RLO), 32'h0, x);
		check("read data", x, lo);
		ahb(1'b0, ra(p, DPR_OFF_RPAR), 32'h0, x);
		check("read parity", {28'h0, x[3:0]}, {28'h0, par});
	endtask : pchk

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		logic [31:0] x;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		pchk(1'b0, INIT_A[31:0], 4'h0);
		pchk(1'b1, INIT_B[31:0], 4'h0);
		ahb(1'b0, 32'h0000_0040, 32'h0, x);
		check("unmapped", x, 32'h0);
		ahb(1'b0, ra(1'b0, DPR_OFF_CMD), 32'h0, x);
		check("command reset", x, DPR_CMD_RESET);
		$display("test reset done");
		// array preloaded by reset, read through one edge
		op(1'b0, 16'h0003, 4'h0, 3'h2, 32'h0, 4'h0);
		pchk(1'b0, FILL, FILL[15:12]);
		op(1'b0, 16'h0005, 4'hF, 3'h2, 32'hDEAD_BEEF, 4'h9);
		pchk(1'b0, 32'hDEAD_BEEF, 4'h9);
		op(1'b1, 16'h0005, 4'h0, 3'h3, 32'h0, 4'h0);
		pchk(1'b1, 32'hDEAD_BEEF, 4'h9);
		$display("test write-through done");
		op(1'b0, 16'h0005, 4'h5, 3'h2, 32'h1122_3344, 4'h6);
		op(1'b0, 16'h0005, 4'h0, 3'h2, 32'h0, 4'h0);
		pchk(1'b0, 32'hDE22_BE44, 4'hC);
		$display("test byte lanes done");
		op(1'b1, 16'h0005, 4'hF, 3'h3, 32'h0BAD_F00D, 4'h3);
		pchk(1'b1, 32'hDE22_BE44, 4'hC);
		op(1'b0, 16'h0005, 4'h0, 3'h2, 32'h0, 4'h0);
		pchk(1'b0, 32'h0BAD_F00D, 4'h3);
		$display("test read-first done");
		// write request with the port disabled must leave all alone
		op(1'b0, 16'h0005, 4'hF, 3'h0, 32'h5555_5555, 4'hF);
		pchk(1'b0, 32'h0BAD_F00D, 4'h3);
		op(1'b0, 16'h0005, 4'h0, 3'h2, 32'h0, 4'h0);
		pchk(1'b0, 32'h0BAD_F00D, 4'h3);
		$display("test disabled port done");
		op(1'b0, 16'h0003, 4'h0, 3'h6, 32'h0, 4'h0);
		pchk(1'b0, INIT_A[31:0], 4'h0);
		op(1'b0, 16'h0003, 4'h0, 3'h2, 32'h0, 4'h0);
		op(1'b0, 16'h0003, 4'h0, 3'h4, 32'h0, 4'h0);
		pchk(1'b0, FILL, 4'h5);
		$display("test set/reset done");
		// register enable low freezes port B, then register enable alone, with the port disabled, loads it
		op(1'b1, 16'h0003, 4'h0, 3'h2, 32'h0, 4'h0);
		pchk(1'b1, 32'hDE22_BE44, 4'hC);
		op(1'b1, 16'h0003, 4'h0, 3'h1, 32'h0, 4'h0);
		pchk(1'b1, FILL, 4'h5);
		// register set/reset leaves the latch, which reloads the register next edge
		op(1'b1, 16'h0003, 4'h0, 3'h5, 32'h0, 4'h0);
		pchk(1'b1, FILL, 4'h5);
		$display("test output register done");
		results();
	end
endmodule : tb_top

`default_nettype wire
